// ===== lpc_map.svh
// constants for the low-power clock stop design
`ifndef LPC_MAP_SVH
`define LPC_MAP_SVH
`define LPC_FC_SUP_DATA 3'h5
`define LPC_FC_SUP_PROG 3'h6
`define LPC_IPL_NMI     3'h7
`define LPC_CYC_16      3'h3
`define LPC_CYC_8       3'h4
`define LPC_CNT_ZERO    3'h0
`define LPC_CNT_ONE     3'h1
`define LPC_PC_STEP     24'h000002
`define LPC_WR_BYTE     8'h00
`define LPC_STATUS_RESET 16'h2700
`define LPC_ADDR_ZERO   24'h000000
`define LPC_MASK_HI     10
`define LPC_MASK_LO     8
`endif

// ===== lpc_pkg.sv
// state types for both ends
package lpc_pkg;
    typedef enum logic [2:0] {
        LPC_DEV_IDLE  = 3'h0,
        LPC_DEV_WRITE = 3'h1,
        LPC_DEV_OPF   = 3'h2,
        LPC_DEV_IMM   = 3'h3,
        LPC_DEV_HALT  = 3'h4,
        LPC_DEV_RET   = 3'h5
    } lpc_dev_state_t;
    typedef enum logic [2:0] {
        LPC_GL_IDLE    = 3'h0,
        LPC_GL_COUNT   = 3'h1,
        LPC_GL_STOPPED = 3'h2,
        LPC_GL_CLKREQ  = 3'h3,
        LPC_GL_RESTART = 3'h4,
        LPC_GL_RESUME  = 3'h5
    } lpc_gl_state_t;
endpackage : lpc_pkg

// ===== lpc_bus_if.sv
// processor bus between the processor end and the clock stop glue
interface lpc_bus_if;
    logic [23:0] address_lines;
    logic [15:0] data_lines;
    logic        data_oe_lo;
    logic        data_oe_hi;
    logic [2:0]  function_code;
    logic        rw;
    logic        bus_strobe;
    logic        cycle_end;
    logic        bus_oe;
    logic        bus_request;
    logic        bus_grant;
    logic [2:0]  interrupt_level_in;
    logic        proc_clk_en;
    logic        bus_width_8;
    modport dev (
        output address_lines, data_lines, data_oe_lo, data_oe_hi,
        output function_code, rw, bus_strobe, cycle_end, bus_oe, bus_grant,
        input  bus_request, interrupt_level_in, proc_clk_en, bus_width_8
    );
    modport glue (
        input  address_lines, data_lines, data_oe_lo, data_oe_hi,
        input  function_code, rw, bus_strobe, cycle_end, bus_oe, bus_grant,
        output bus_request, interrupt_level_in, proc_clk_en, bus_width_8
    );
endinterface : lpc_bus_if

// ===== lpc_cycle_counter.sv
// bus cycle counter from the low-power write to the stop operand fetch
`include "lpc_map.svh"
module lpc_cycle_counter
    import lpc_pkg::*;
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic reset,
    // counting
    input  wire logic start,
    input  wire logic step,
    input  wire logic mode_8bit,
    output wire logic count_last,
    output wire logic count_done
);
    logic [2:0] count_r;
    logic       active_r;
    wire  [2:0] target    = mode_8bit ? `LPC_CYC_8 : `LPC_CYC_16;
    wire  [2:0] count_inc = count_r + `LPC_CNT_ONE;
    wire        at_last   = active_r && (count_inc == target);

    assign count_last = at_last;
    assign count_done = at_last && step;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            count_r  <= `LPC_CNT_ZERO;
            active_r <= 1'b0;
        end else if (start) begin
            count_r  <= `LPC_CNT_ONE;
            active_r <= 1'b1;
        end else if (count_done) begin
            count_r  <= `LPC_CNT_ZERO;
            active_r <= 1'b0;
        end else if (active_r && step) begin
            count_r  <= count_inc;
        end
    end
endmodule : lpc_cycle_counter

// ===== lpc_glue.sv
// clock stop glue: detects entry, gates the processor clock, wakes it
`include "lpc_map.svh"
module lpc_glue
    import lpc_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // processor bus
    lpc_bus_if.glue          bus,
    // configuration
    input  wire logic [23:0] lp_addr,
    input  wire logic        mode_8bit,
    input  wire logic        float_en,
    input  wire logic [2:0]  wake_level,
    // interrupt source
    input  wire logic [2:0]  irq_level,
    // system clock source
    input  wire logic        sysclk_stable,
    output logic             sysclk_run_req,
    // clock and status
    output wire logic        proc_clk,
    output logic             restart,
    output logic             low_power
);
    lpc_gl_state_t state_r;
    lpc_gl_state_t state_nxt;
    logic          gate_en_r;
    logic          bus_req_r;
    logic          bus_req_nxt;
    logic [2:0]    ipl_r;
    logic          width_8_r;
    logic          count_last;
    logic          count_done;
    logic          float_r;

    // clock held off while stopped or waiting for the source
    function automatic logic gate_off_state(input lpc_gl_state_t s);
        return (s == LPC_GL_STOPPED) || (s == LPC_GL_CLKREQ);
    endfunction : gate_off_state

    // source clock wanted from the wake until back in idle
    function automatic logic sysclk_needed(input lpc_gl_state_t s);
        return (s == LPC_GL_CLKREQ) || (s == LPC_GL_RESTART)
               || (s == LPC_GL_RESUME);
    endfunction : sysclk_needed

    // supervisor data write to the chosen address
    wire addr_hit = bus.address_lines == lp_addr;
    wire code_hit = bus.function_code == `LPC_FC_SUP_DATA;
    wire lp_match = bus.bus_strobe && !bus.rw && code_hit && addr_hit;
    // the handler write opens the sequence
    // only idle starts a count; later matches are ignored
    wire cnt_start = (state_r == LPC_GL_IDLE) && lp_match
                     && bus.cycle_end;
    wire wake_hit = ipl_r == wake_level;
    // gate held off only while stopped
    // and while the source clock is still settling
    wire gate_want = !gate_off_state(state_r);

    // count bus cycles from the write
    // target grows by one in 8-bit mode
    lpc_cycle_counter u_count (
        .core_clk   (core_clk),
        .reset      (reset),
        .start      (cnt_start),
        .step       (bus.cycle_end),
        .mode_8bit  (width_8_r),
        .count_last (count_last),
        .count_done (count_done)
    );

    always_comb begin
        state_nxt   = state_r;
        bus_req_nxt = bus_req_r;
        case (state_r)
            LPC_GL_IDLE: begin
                if (cnt_start) begin
                    state_nxt = LPC_GL_COUNT;
                end
            end
            LPC_GL_COUNT: begin
                // request the bus during the operand fetch
                if (count_last && float_r) begin
                    bus_req_nxt = 1'b1;
                end
                // stop once the operand cycle ends
                if (count_done) begin
                    state_nxt = LPC_GL_STOPPED;
                end
            end
            LPC_GL_STOPPED: begin
                // leave only on the chosen level
                if (wake_hit) begin
                    state_nxt = LPC_GL_CLKREQ;
                end
            end
            LPC_GL_CLKREQ: begin
                // clock must be stable before restart
                if (sysclk_stable) begin
                    state_nxt = LPC_GL_RESTART;
                end
            end
            LPC_GL_RESTART: begin
                state_nxt = LPC_GL_RESUME;
            end
            LPC_GL_RESUME: begin
                // release the bus after the restart
                bus_req_nxt = 1'b0;
                state_nxt   = LPC_GL_IDLE;
            end
            default: begin
                state_nxt   = LPC_GL_IDLE;
                bus_req_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_r   <= LPC_GL_IDLE;
            bus_req_r <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            bus_req_r <= bus_req_nxt;
        end
    end

    // clock request held until back in idle
    wire run_req_nxt   = sysclk_needed(state_nxt);
    wire restart_nxt   = state_nxt == LPC_GL_RESTART;
    wire low_power_nxt = gate_off_state(state_nxt);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            sysclk_run_req <= 1'b0;
            restart        <= 1'b0;
            low_power      <= 1'b0;
        end else begin
            sysclk_run_req <= run_req_nxt;
            restart        <= restart_nxt;
            low_power      <= low_power_nxt;
        end
    end

    // float choice latched at the write, so a late change
    // cannot raise the request halfway through a fetch
    always_ff @(posedge core_clk) begin
        if (reset) begin
            float_r <= 1'b0;
        end else if (cnt_start) begin
            float_r <= float_en;
        end
    end

    // interrupt level passed on registered
    // one clock of level delay before a wake is seen
    // width select registered every clock, cleared to 16-bit in reset
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ipl_r     <= `LPC_CNT_ZERO;
            width_8_r <= 1'b0;
        end else begin
            ipl_r     <= irq_level;
            width_8_r <= mode_8bit;
        end
    end

    // enable changes only while the clock is low
    // a restart takes effect at the next fall
    // reset is seen on the low phase too, so the gate opens in reset
    always_ff @(negedge core_clk) begin
        if (reset) begin
            gate_en_r <= 1'b1;
        end else begin
            gate_en_r <= gate_want;
        end
    end

    // and with a low-phase enable cannot clip a pulse
    assign proc_clk               = core_clk & gate_en_r;
    assign bus.proc_clk_en        = gate_en_r;
    // request wire only, grant comes back
    assign bus.bus_request        = bus_req_r;
    assign bus.interrupt_level_in = ipl_r;
    assign bus.bus_width_8        = width_8_r;
endmodule : lpc_glue

// ===== lpc_proc_end.sv
// processor end: low-power entry bus cycles, stop and wake
`include "lpc_map.svh"
module lpc_proc_end
    import lpc_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // processor bus
    lpc_bus_if.dev           bus,
    // software side
    input  wire logic        entry_start,
    input  wire logic        supervisor,
    input  wire logic [23:0] handler_pc,
    input  wire logic [23:0] lp_addr,
    input  wire logic [15:0] prog_word,
    // status
    output logic [15:0]      status_word,
    output wire logic        halted,
    output logic             entry_done
);
    lpc_dev_state_t state_r;
    lpc_dev_state_t state_nxt;
    logic        ph_r;
    logic        byte2_r;
    logic [7:0]  imm_hi_r;
    logic [23:0] pc_r;
    logic [23:0] addr_r;
    logic [2:0]  fc_r;
    logic        rw_r;
    logic        grant_r;

    // a stopped clock freezes every register except entry_done, which clears
    wire run    = bus.proc_clk_en;
    wire strobe = (state_r == LPC_DEV_WRITE) || (state_r == LPC_DEV_OPF)
                  || (state_r == LPC_DEV_IMM);
    wire cyc_end = strobe && ph_r;
    wire w8      = bus.bus_width_8;
    // in 8-bit mode the operand takes two byte cycles
    wire imm_last = !w8 || byte2_r;
    wire [15:0] operand = w8 ? {imm_hi_r, prog_word[7:0]} : prog_word;
    // the loaded mask decides which level wakes
    wire [2:0] mask = status_word[`LPC_MASK_HI:`LPC_MASK_LO];
    wire ipl_pass = (bus.interrupt_level_in == `LPC_IPL_NMI)
                    || (bus.interrupt_level_in > mask);
    // no execution while the bus is still requested
    wire bus_free = !grant_r && !bus.bus_request;
    wire [23:0] pc_inc = pc_r + `LPC_PC_STEP;
    // next fetch address is presented with its step already taken
    wire        pc_step = cyc_end && (state_r != LPC_DEV_WRITE);
    wire [23:0] pc_cur  = pc_step ? pc_inc : pc_r;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            LPC_DEV_IDLE: if (entry_start && supervisor) begin
                state_nxt = LPC_DEV_WRITE;
            end
            LPC_DEV_WRITE: if (cyc_end) begin
                state_nxt = LPC_DEV_OPF;
            end
            LPC_DEV_OPF: if (cyc_end) begin
                state_nxt = LPC_DEV_IMM;
            end
            LPC_DEV_IMM: if (cyc_end && imm_last) begin
                state_nxt = LPC_DEV_HALT;
            end
            LPC_DEV_HALT: if (ipl_pass && bus_free) begin
                state_nxt = LPC_DEV_RET;
            end
            LPC_DEV_RET: state_nxt = LPC_DEV_IDLE;
            default: state_nxt = LPC_DEV_IDLE;
        endcase
    end

    wire [23:0] addr_nxt = (state_nxt == LPC_DEV_WRITE) ? lp_addr : pc_cur;
    wire [2:0]  fc_nxt   = (state_nxt == LPC_DEV_WRITE) ? `LPC_FC_SUP_DATA
                                                        : `LPC_FC_SUP_PROG;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_r <= LPC_DEV_IDLE;
            ph_r    <= 1'b0;
            byte2_r <= 1'b0;
            addr_r  <= `LPC_ADDR_ZERO;
            fc_r    <= `LPC_FC_SUP_PROG;
            rw_r    <= 1'b1;
        end else if (run) begin
            state_r <= state_nxt;
            ph_r    <= strobe && !ph_r;
            byte2_r <= (state_r == LPC_DEV_IMM) && (byte2_r ^ cyc_end);
            addr_r  <= addr_nxt;
            fc_r    <= fc_nxt;
            rw_r    <= state_nxt != LPC_DEV_WRITE;
        end
    end

    // fetch address walks on each fetch cycle end
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pc_r <= `LPC_ADDR_ZERO;
        end else if (run) begin
            if (state_r == LPC_DEV_IDLE) begin
                pc_r <= handler_pc;
            end else if (pc_step) begin
                pc_r <= pc_inc;
            end
        end
    end

    // status word takes the stop operand
    always_ff @(posedge core_clk) begin
        if (reset) begin
            status_word <= `LPC_STATUS_RESET;
            imm_hi_r    <= `LPC_WR_BYTE;
        end else if (run && state_r == LPC_DEV_IMM && cyc_end) begin
            if (imm_last) begin
                status_word <= operand;
            end else begin
                imm_hi_r <= prog_word[7:0];
            end
        end
    end

    // grant at a cycle boundary, drop with request
    always_ff @(posedge core_clk) begin
        if (reset) begin
            grant_r    <= 1'b0;
            entry_done <= 1'b0;
        end else if (run) begin
            grant_r    <= bus.bus_request && (grant_r || cyc_end || !strobe);
            entry_done <= state_r == LPC_DEV_RET;
        end else begin
            entry_done <= 1'b0;
        end
    end

    assign halted            = state_r == LPC_DEV_HALT;
    assign bus.address_lines = addr_r;
    assign bus.function_code = fc_r;
    assign bus.rw            = rw_r;
    assign bus.bus_strobe    = strobe;
    assign bus.cycle_end     = cyc_end;
    assign bus.bus_oe        = !grant_r;
    assign bus.bus_grant     = grant_r;
    // upper lane undriven in 8-bit mode
    assign bus.data_lines    = {`LPC_WR_BYTE, `LPC_WR_BYTE};
    assign bus.data_oe_lo    = !rw_r && !grant_r;
    assign bus.data_oe_hi    = !rw_r && !grant_r && !w8;
endmodule : lpc_proc_end

// ===== lpc_assertions.sv
// concurrent checks on the processor bus joining both ends
module lpc_assertions (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        reset,
    // bus signals
    input wire logic [23:0] address_lines,
    input wire logic [15:0] data_lines,
    input wire logic        data_oe_lo,
    input wire logic        data_oe_hi,
    input wire logic [2:0]  function_code,
    input wire logic        rw,
    input wire logic        bus_strobe,
    input wire logic        cycle_end,
    input wire logic        bus_oe,
    input wire logic        bus_grant,
    input wire logic        bus_request,
    input wire logic        proc_clk_en,
    input wire logic        bus_width_8
);
    logic [2:0] cyc_cnt_r;
    logic [2:0] cyc_cnt_nxt;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_write_end;
        cycle_end && !rw && function_code == 3'h5;
    endsequence
    sequence s_fetch;
        bus_strobe && rw && function_code == 3'h6 ##1 cycle_end;
    endsequence

    // restarts at the write, so a stray earlier cycle cannot shift the count
    assign cyc_cnt_nxt = (cycle_end && !rw) ? 3'h1 : cyc_cnt_r + {2'h0, cycle_end};
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cyc_cnt_r <= 3'h0;
        end else begin
            cyc_cnt_r <= cyc_cnt_nxt;
        end
    end

    a_entry_order: assert property (s_write_end |=> s_fetch ##1 s_fetch)
        else $error("fetches do not follow the low-power write");
    a_stop_count: assert property ($fell(proc_clk_en) |-> cyc_cnt_r == (bus_width_8 ? 3'h4 : 3'h3))
        else $error("clock stopped after wrong number of bus cycles");
    a_cycle_frame: assert property (cycle_end |-> bus_strobe && $past(bus_strobe) && !$past(cycle_end))
        else $error("bus cycle end without a two-clock strobe");
    a_fields_stand: assert property (bus_strobe && !cycle_end |=> $stable(address_lines) && $stable(function_code) && $stable(rw))
        else $error("address or code changed inside a bus cycle");
    a_write_fields: assert property (bus_strobe && !rw |-> function_code == 3'h5 && data_lines[7:0] == 8'h00)
        else $error("low-power write with wrong code or data");
    a_frozen_stop: assert property (!proc_clk_en |=> $stable(address_lines) && $stable(bus_grant) && !bus_strobe)
        else $error("processor state moved while clock gated");
    a_grant_needs_req: assert property ($rose(bus_grant) |-> $past(bus_request))
        else $error("grant without request");
    a_grant_quiet: assert property (bus_grant |-> !bus_strobe && !bus_oe && !data_oe_lo && !data_oe_hi)
        else $error("bus driven while granted");
    a_grant_release: assert property (bus_grant && !bus_request |-> ##[0:2] !bus_grant)
        else $error("grant held after request dropped");
    a_narrow_lanes: assert property (bus_width_8 |-> !data_oe_hi)
        else $error("upper lane driven in 8-bit mode");
endmodule : lpc_assertions

// ===== low_power_clock_stop_ctrl_tb.sv
// self-checking bench: processor end and glue joined across the bus
module low_power_clock_stop_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk;
    logic        reset;
    logic        entry_start;
    logic        supervisor;
    logic [23:0] proc_lp_addr;
    logic [23:0] glue_lp_addr;
    logic [15:0] prog_word;
    logic        mode_8bit;
    logic        float_en;
    logic [2:0]  wake_level;
    logic [2:0]  irq_level;
    logic        sysclk_stable;
    logic        sysclk_run_req;
    logic        proc_clk;
    logic        restart;
    logic        low_power;
    logic [15:0] status_word;
    logic        halted;
    logic        entry_done;
    int          n_mismatch;
    int          check_count;
    int          i;

    lpc_bus_if bus ();
    lpc_glue i_lpc_glue (.core_clk(core_clk), .reset(reset), .bus(bus), .lp_addr(glue_lp_addr),
        .mode_8bit(mode_8bit), .float_en(float_en), .wake_level(wake_level), .irq_level(irq_level),
        .sysclk_stable(sysclk_stable), .sysclk_run_req(sysclk_run_req), .proc_clk(proc_clk),
        .restart(restart), .low_power(low_power));
    lpc_proc_end i_lpc_proc_end (.core_clk(core_clk), .reset(reset), .bus(bus), .entry_start(entry_start),
        .supervisor(supervisor), .handler_pc(24'h000400), .lp_addr(proc_lp_addr), .prog_word(prog_word),
        .status_word(status_word), .halted(halted), .entry_done(entry_done));
    lpc_assertions i_lpc_assertions (.core_clk(core_clk), .reset(reset), .address_lines(bus.address_lines),
        .data_lines(bus.data_lines), .data_oe_lo(bus.data_oe_lo), .data_oe_hi(bus.data_oe_hi),
        .function_code(bus.function_code), .rw(bus.rw), .bus_strobe(bus.bus_strobe),
        .cycle_end(bus.cycle_end), .bus_oe(bus.bus_oe), .bus_grant(bus.bus_grant),
        .bus_request(bus.bus_request), .proc_clk_en(bus.proc_clk_en), .bus_width_8(bus.bus_width_8));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge core_clk);
            #1;
        end
    endtask : tick

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // a wait that ran out ends the run at once
    task automatic bound(input string what, input logic seen);
        chk(what, 16'h0001, {15'h0000, seen});
        if (seen !== 1'b1) begin
            summarize();
        end
    endtask : bound

    task automatic enter();
        entry_start = 1'b1;
        tick(1);
        entry_start = 1'b0;
    endtask : enter

    task automatic test_entry16();
        glue_lp_addr = 24'hffffff;
        proc_lp_addr = 24'hffffff;
        wake_level = 3'h3;
        enter();
        for (i = 0; i < 30 && low_power !== 1'b1; i++) tick(1);
        bound("low_power", low_power);
        chk("status_word", 16'h2000, status_word);
        irq_level = 3'h2;
        tick(4);
        chk("gate held", 16'h0000, {15'h0000, bus.proc_clk_en});
        chk("run_req on other level", 16'h0000, {15'h0000, sysclk_run_req});
        chk("status frozen", 16'h2000, status_word);
        chk("proc_clk gated", 16'h0000, {15'h0000, proc_clk});
        irq_level = 3'h3;
        for (i = 0; i < 10 && sysclk_run_req !== 1'b1; i++) tick(1);
        bound("sysclk_run_req", sysclk_run_req);
        tick(3);
        chk("restart before stable", 16'h0000, {15'h0000, restart});
        sysclk_stable = 1'b1;
        for (i = 0; i < 10 && restart !== 1'b1; i++) tick(1);
        bound("restart", restart);
        tick(1);
        chk("gate on", 16'h0001, {15'h0000, bus.proc_clk_en});
        chk("proc_clk running", 16'h0001, {15'h0000, proc_clk});
        for (i = 0; i < 10 && entry_done !== 1'b1; i++) tick(1);
        bound("entry_done", entry_done);
        chk("low_power off", 16'h0000, {15'h0000, low_power});
        irq_level = 3'h0;
        sysclk_stable = 1'b0;
        $display("test entry16 done");
    endtask : test_entry16

    task automatic test_refused();
        supervisor = 1'b0;
        enter();
        tick(6);
        chk("strobe in user mode", 16'h0000, {15'h0000, bus.bus_strobe});
        supervisor = 1'b1;
        glue_lp_addr = 24'h000010;
        proc_lp_addr = 24'h000011;
        enter();
        for (i = 0; i < 30 && halted !== 1'b1; i++) tick(1);
        bound("halted", halted);
        tick(3);
        chk("no stop on other address", 16'h0001, {15'h0000, bus.proc_clk_en});
        chk("low_power", 16'h0000, {15'h0000, low_power});
        irq_level = 3'h7;
        for (i = 0; i < 10 && entry_done !== 1'b1; i++) tick(1);
        bound("entry_done", entry_done);
        irq_level = 3'h0;
        $display("test refused done");
    endtask : test_refused

    task automatic test_entry8_float();
        reset = 1'b1;
        mode_8bit = 1'b1;
        float_en = 1'b1;
        glue_lp_addr = 24'h000001;
        proc_lp_addr = 24'h000001;
        prog_word = 16'h0024;
        wake_level = 3'h5;
        tick(2);
        reset = 1'b0;
        enter();
        for (i = 0; i < 30 && low_power !== 1'b1; i++) tick(1);
        bound("low_power", low_power);
        tick(2);
        chk("status_word", 16'h2424, status_word);
        chk("bus_grant", 16'h0001, {15'h0000, bus.bus_grant});
        irq_level = 3'h5;
        for (i = 0; i < 10 && sysclk_run_req !== 1'b1; i++) tick(1);
        bound("sysclk_run_req", sysclk_run_req);
        sysclk_stable = 1'b1;
        for (i = 0; i < 10 && restart !== 1'b1; i++) tick(1);
        bound("restart", restart);
        chk("halted while requested", 16'h0001, {15'h0000, halted});
        for (i = 0; i < 10 && entry_done !== 1'b1; i++) tick(1);
        bound("entry_done", entry_done);
        chk("bus_request", 16'h0000, {15'h0000, bus.bus_request});
        chk("bus_grant", 16'h0000, {15'h0000, bus.bus_grant});
        $display("test entry8 float done");
    endtask : test_entry8_float

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    initial begin
        reset = 1'b1;
        entry_start = 1'b0;
        supervisor = 1'b1;
        proc_lp_addr = 24'h000000;
        glue_lp_addr = 24'h000000;
        prog_word = 16'h2000;
        mode_8bit = 1'b0;
        float_en = 1'b0;
        wake_level = 3'h0;
        irq_level = 3'h0;
        sysclk_stable = 1'b0;
        n_mismatch = 0;
        check_count = 0;
        tick(12);
        reset = 1'b0;
        test_entry16();
        test_refused();
        test_entry8_float();
        summarize();
    end
endmodule : low_power_clock_stop_ctrl_tb
